// File: common/sfb_pkg.sv
// Register map, field layout and bus carriers of the SPI format and baud block
package sfb_pkg;
   // ===================================================
   // Register indexes, byte address is four times each
   localparam int unsigned AW       = 10;
   localparam logic [7:0]  IDX_FMT  = 8'h0C;
   localparam logic [7:0]  IDX_DIV  = 8'h0D;
   localparam logic [7:0]  IDX_CTL  = 8'h20;
   localparam logic [7:0]  IDX_STAT = 8'h21;
   localparam logic [7:0]  IDX_DATA = 8'h22;

   // ===================================================
   // Reset values and field positions
   localparam logic [7:0]  FMT_RST   = 8'h00;
   localparam logic [7:0]  DIV_RST   = 8'h00;
   localparam logic [7:0]  CTL_RST   = 8'h00;
   localparam logic [3:0]  FLG_RST   = 4'h0;
   localparam logic [7:0]  FMT_WMASK = 8'hC7;
   localparam int unsigned F_CPOL    = 0;
   localparam int unsigned F_CPHA    = 1;
   localparam int unsigned F_CHR     = 2;
   localparam int unsigned F_SAS     = 6;
   localparam int unsigned F_IE      = 7;
   localparam int unsigned C_MST     = 0;
   localparam int unsigned C_MODFE   = 1;
   localparam int unsigned S_MODE_FAULT_FLAG    = 0;
   localparam int unsigned S_WRITE_COLLISION_FLAG    = 1;
   localparam int unsigned S_RECEIVE_OVERRUN_FLAG    = 2;
   localparam int unsigned S_DONE    = 3;

   // ===================================================
   // Transfer lengths in bits and index of the last clock edge
   localparam logic [4:0]  BITS_8   = 5'h08;
   localparam logic [4:0]  BITS_16  = 5'h10;
   localparam logic [4:0]  EDGES_8  = 5'h0F;
   localparam logic [4:0]  EDGES_16 = 5'h1F;

   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;

   // ===================================================
   // Types
   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_RUN  = 2'b10
   } sfb_state_t;

   typedef enum logic [5:0] {
      SEL_NONE = 6'b000001,
      SEL_FMT  = 6'b000010,
      SEL_DIV  = 6'b000100,
      SEL_CTL  = 6'b001000,
      SEL_STAT = 6'b010000,
      SEL_DATA = 6'b100000
   } sfb_sel_t;

   typedef struct packed {
      logic          awvalid;
      logic [AW-1:0] awaddr;
      logic          wvalid;
      logic [31:0]   wdata;
      logic [3:0]    wstrb;
      logic          bready;
      logic          arvalid;
      logic [AW-1:0] araddr;
      logic          rready;
   } sfb_axi_req_t;

   typedef struct packed {
      logic          awready;
      logic          wready;
      logic          bvalid;
      logic [1:0]    bresp;
      logic          arready;
      logic          rvalid;
      logic [31:0]   rdata;
      logic [1:0]    rresp;
   } sfb_axi_rsp_t;

   function automatic sfb_sel_t decode(input logic [AW-1:0] addr);
      logic [7:0] idx;
      idx = addr[AW-1:2];
      if (addr[1:0] != 2'h0) decode = SEL_NONE;
      else if (idx == IDX_FMT) decode = SEL_FMT;
      else if (idx == IDX_DIV) decode = SEL_DIV;
      else if (idx == IDX_CTL) decode = SEL_CTL;
      else if (idx == IDX_STAT) decode = SEL_STAT;
      else if (idx == IDX_DATA) decode = SEL_DATA;
      else decode = SEL_NONE;
   endfunction : decode
endpackage : sfb_pkg

// File: design/sfb_baud_gen.sv
// Bit-rate tick generator for the serial clock in master operation
`timescale 1ns/1ps
`default_nettype none
module sfb_baud_gen #(
   parameter int unsigned W = 8
) (
   input  wire logic         i_sys_clk,
   input  wire logic         i_rst,
   input  wire logic         i_en,
   input  wire logic [W-1:0] i_ratio,
   output logic              o_tick
);
   logic [W-1:0] cnt_r;
   logic [W-1:0] cnt_nxt;
   wire          wrap;

   // One tick every ratio plus one cycles, a half period
   assign wrap    = (cnt_r >= i_ratio);
   assign cnt_nxt = wrap ? {W{1'b0}} : cnt_r + 1'b1;
   assign o_tick  = i_en & wrap;

   always_ff @(posedge i_sys_clk) begin
      if (i_rst || !i_en) cnt_r <= {W{1'b0}};
      else cnt_r <= cnt_nxt;
   end

   // ===================================================
   // Checks
   a_tick_spacing: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      o_tick && i_en ##1 i_en && $stable(i_ratio) |-> o_tick == (i_ratio == {W{1'b0}}))
      else $error("baud tick spacing wrong");
endmodule : sfb_baud_gen
`default_nettype wire

// File: design/sfb_spi_top.sv
// SPI port with format configuration, clock divider and AXI4-Lite registers
`timescale 1ns/1ps
`default_nettype none
module sfb_spi_top (
   input  wire logic                  i_sys_clk,
   input  wire logic                  i_rst,
   input  wire sfb_pkg::sfb_axi_req_t i_axi,
   output var  sfb_pkg::sfb_axi_rsp_t o_axi,
   input  wire logic                  i_sclk,
   output logic                       o_sclk,
   output logic                       o_sclk_oe,
   input  wire logic                  i_mosi,
   output logic                       o_mosi,
   output logic                       o_mosi_oe,
   input  wire logic                  i_miso,
   output logic                       o_miso,
   output logic                       o_miso_oe,
   input  wire logic                  i_ssel,
   output logic                       o_irq
);
   // ===================================================
   // Pin synchronisers
   logic [2:0] sck_q;
   logic [2:0] ss_q;
   logic [1:0] mosi_q;
   logic [1:0] miso_q;

   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         sck_q  <= 3'h0;
         // Start deselected so no false select edge follows reset
         ss_q   <= 3'h7;
         mosi_q <= 2'h0;
         miso_q <= 2'h0;
      end else begin
         sck_q  <= {sck_q[1:0], i_sclk};
         ss_q   <= {ss_q[1:0], i_ssel};
         mosi_q <= {mosi_q[0], i_mosi};
         miso_q <= {miso_q[0], i_miso};
      end
   end

   // ===================================================
   // State and configuration
   logic [7:0]          fmt_r;
   logic [7:0]          div_r;
   logic [7:0]          ctl_r;
   logic [3:0]          flg_r;
   logic [3:0]          flg_nxt;
   logic [15:0]         tx_r;
   logic [15:0]         tx_nxt;
   logic [15:0]         rx_r;
   logic [15:0]         rx_nxt;
   logic [15:0]         rxb_r;
   logic                rxf_r;
   logic [4:0]          ecnt_r;
   logic [4:0]          ecnt_nxt;
   logic                sclk_r;
   logic                irq_r;
   sfb_pkg::sfb_state_t state_r;
   sfb_pkg::sfb_state_t state_nxt;

   wire cpol  = fmt_r[sfb_pkg::F_CPOL];
   wire cpha  = fmt_r[sfb_pkg::F_CPHA];
   wire chr   = fmt_r[sfb_pkg::F_CHR];
   wire select_level_bit   = fmt_r[sfb_pkg::F_SAS];
   wire ie    = fmt_r[sfb_pkg::F_IE];
   wire mst   = ctl_r[sfb_pkg::C_MST];
   wire modfe = ctl_r[sfb_pkg::C_MODFE];
   wire busy  = (state_r == sfb_pkg::ST_RUN);

   // ===================================================
   // Register bus slave
   logic                 aw_full_r;
   logic                 w_full_r;
   logic [sfb_pkg::AW-1:0] awaddr_r;
   logic [31:0]          wdata_r;
   logic [3:0]           wstrb_r;
   logic                 bvalid_r;
   logic [1:0]           bresp_r;
   logic                 rvalid_r;
   logic [31:0]          rdata_r;
   logic [1:0]           rresp_r;
   logic [31:0]          rd_val;

   wire              aw_rdy  = !aw_full_r && !bvalid_r;
   wire              w_rdy   = !w_full_r && !bvalid_r;
   wire              wr_go   = aw_full_r && w_full_r && !bvalid_r;
   wire              ar_rdy  = !rvalid_r;
   wire              rd_go   = i_axi.arvalid && ar_rdy;
   sfb_pkg::sfb_sel_t wsel;
   sfb_pkg::sfb_sel_t rsel;
   assign wsel = sfb_pkg::decode(awaddr_r);
   assign rsel = sfb_pkg::decode(i_axi.araddr);

   wire wr_lo   = wr_go && wstrb_r[0];
   wire wr_fmt  = wr_lo && (wsel == sfb_pkg::SEL_FMT);
   wire wr_div  = wr_lo && (wsel == sfb_pkg::SEL_DIV);
   wire wr_ctl  = wr_lo && (wsel == sfb_pkg::SEL_CTL);
   wire wr_stat = wr_lo && (wsel == sfb_pkg::SEL_STAT);
   wire wr_data = wr_lo && (wsel == sfb_pkg::SEL_DATA);
   wire rd_data = rd_go && (rsel == sfb_pkg::SEL_DATA);

   assign rd_val =
      (rsel == sfb_pkg::SEL_FMT)  ? {24'h000000, fmt_r} :
      (rsel == sfb_pkg::SEL_DIV)  ? {24'h000000, div_r} :
      (rsel == sfb_pkg::SEL_CTL)  ? {24'h000000, ctl_r} :
      (rsel == sfb_pkg::SEL_STAT) ? {24'h000000, busy, 3'h0, flg_r} :
      (rsel == sfb_pkg::SEL_DATA) ? {16'h0000, rxb_r} : 32'h00000000;

   always_ff @(posedge i_sys_clk) begin
      if (i_rst || wr_go) aw_full_r <= 1'b0;
      else if (i_axi.awvalid && aw_rdy) aw_full_r <= 1'b1;
      if (i_rst || wr_go) w_full_r <= 1'b0;
      else if (i_axi.wvalid && w_rdy) w_full_r <= 1'b1;
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_axi.awvalid && aw_rdy) awaddr_r <= i_axi.awaddr;
      if (i_axi.wvalid && w_rdy) begin
         wdata_r <= i_axi.wdata;
         wstrb_r <= i_axi.wstrb;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         bvalid_r <= 1'b0;
         bresp_r  <= sfb_pkg::RESP_OKAY;
      end else if (wr_go) begin
         bvalid_r <= 1'b1;
         bresp_r  <= (wsel == sfb_pkg::SEL_NONE) ? sfb_pkg::RESP_SLVERR : sfb_pkg::RESP_OKAY;
      end else if (i_axi.bready) begin
         bvalid_r <= 1'b0;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         rvalid_r <= 1'b0;
         rdata_r  <= 32'h00000000;
         rresp_r  <= sfb_pkg::RESP_OKAY;
      end else if (rd_go) begin
         rvalid_r <= 1'b1;
         rdata_r  <= rd_val;
         rresp_r  <= (rsel == sfb_pkg::SEL_NONE) ? sfb_pkg::RESP_SLVERR : sfb_pkg::RESP_OKAY;
      end else if (i_axi.rready) begin
         rvalid_r <= 1'b0;
      end
   end

   assign o_axi = '{awready: aw_rdy, wready: w_rdy, bvalid: bvalid_r, bresp: bresp_r,
                    arready: ar_rdy, rvalid: rvalid_r, rdata: rdata_r, rresp: rresp_r};

   // ===================================================
   // Select, edges and sampling
   wire ss_act = (ss_q[1] == select_level_bit);
   wire ss_was = (ss_q[2] == select_level_bit);
   wire fault  = mst && modfe && ss_act && !ss_was;
   wire gen_en = mst && busy;
   wire tick;

   sfb_baud_gen #(.W(8)) u_baud (
      .i_sys_clk (i_sys_clk),
      .i_rst     (i_rst),
      .i_en      (gen_en),
      .i_ratio   (div_r),
      .o_tick    (tick)
   );

   wire s_rise = sck_q[1] && !sck_q[2];
   wire s_fall = !sck_q[1] && sck_q[2];
   wire m_edge = tick && busy;
   wire s_edge = !mst && ss_act && (s_rise || s_fall);
   wire edge_ev = mst ? m_edge : s_edge;
   // Leading edge leaves the idle level set by polarity
   wire lead = mst ? (m_edge && sclk_r == cpol)
                   : (s_edge && (cpol ? s_fall : s_rise));
   wire trail = edge_ev && !lead;
   wire samp  = cpha ? trail : lead;
   wire shft  = cpha ? (lead && ecnt_r != 5'h00) : trail;
   wire [4:0] last = chr ? sfb_pkg::EDGES_16 : sfb_pkg::EDGES_8;
   wire done  = edge_ev && (ecnt_r == last);
   wire din   = mst ? miso_q[1] : mosi_q[1];
   wire abort = fault || (!mst && !ss_act);

   // ===================================================
   // Transfer engine
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         sfb_pkg::ST_IDLE: begin
            if (wr_data && mst) state_nxt = sfb_pkg::ST_RUN;
            else if (s_edge) state_nxt = sfb_pkg::ST_RUN;
         end
         sfb_pkg::ST_RUN: begin
            if (done || abort) state_nxt = sfb_pkg::ST_IDLE;
         end
         default: state_nxt = sfb_pkg::ST_IDLE;
      endcase
   end

   assign ecnt_nxt = (done || abort) ? 5'h00 :
                     edge_ev ? ecnt_r + 5'h01 : (busy ? ecnt_r : 5'h00);
   assign rx_nxt = samp ? {rx_r[14:0], din} : rx_r;
   // Short characters sit left aligned so the top bit always leaves first
   assign tx_nxt = (wr_data && !busy) ?
                   (chr ? wdata_r[15:0] : {wdata_r[7:0], 8'h00}) :
                   (shft ? {tx_r[14:0], 1'b0} : tx_r);

   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         state_r <= sfb_pkg::ST_IDLE;
         ecnt_r  <= 5'h00;
         tx_r    <= 16'h0000;
         rx_r    <= 16'h0000;
         sclk_r  <= 1'b0;
      end else begin
         state_r <= state_nxt;
         ecnt_r  <= ecnt_nxt;
         tx_r    <= tx_nxt;
         rx_r    <= rx_nxt;
         sclk_r  <= busy ? (sclk_r ^ m_edge) : cpol;
      end
   end

   // ===================================================
   // Receive buffer and flags
   wire [3:0] hw_set = {done, done && rxf_r, wr_data && busy, fault};
   // Hardware set wins over a software clear in the same cycle
   assign flg_nxt = hw_set | (wr_stat ? wdata_r[3:0] : flg_r);

   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         fmt_r <= sfb_pkg::FMT_RST;
         div_r <= sfb_pkg::DIV_RST;
         ctl_r <= sfb_pkg::CTL_RST;
         flg_r <= sfb_pkg::FLG_RST;
         rxb_r <= 16'h0000;
         rxf_r <= 1'b0;
         irq_r <= 1'b0;
      end else begin
         if (wr_fmt) fmt_r <= wdata_r[7:0] & sfb_pkg::FMT_WMASK;
         if (wr_div) div_r <= wdata_r[7:0];
         if (wr_ctl) begin
            ctl_r[sfb_pkg::C_MODFE] <= wdata_r[sfb_pkg::C_MODFE];
            ctl_r[sfb_pkg::C_MST] <= wdata_r[sfb_pkg::C_MST] && (mst || !ss_act);
         end
         flg_r <= flg_nxt;
         if (done && !rxf_r) rxb_r <= chr ? rx_nxt : {8'h00, rx_nxt[7:0]};
         rxf_r <= done || (rxf_r && !rd_data);
         irq_r <= ie && (flg_nxt != 4'h0);
      end
   end

   assign o_irq     = irq_r;
   assign o_sclk    = sclk_r;
   assign o_sclk_oe = mst;
   assign o_mosi    = tx_r[15];
   assign o_mosi_oe = mst;
   assign o_miso    = tx_r[15];
   assign o_miso_oe = !mst && ss_act;

   // ===================================================
   // Checks
   logic [4:0] scnt_r;
   always_ff @(posedge i_sys_clk) begin
      if (i_rst || done || (!busy && !edge_ev)) scnt_r <= 5'h00;
      else if (samp) scnt_r <= scnt_r + 5'h01;
   end

   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_rst);

   a_reset_zero: assert property (disable iff (1'b0)
      i_rst |=> fmt_r == sfb_pkg::FMT_RST && div_r == sfb_pkg::DIV_RST)
      else $error("format or divider not cleared by reset");
   a_idle_level: assert property (!busy |=> o_sclk == $past(cpol))
      else $error("idle clock level differs from polarity");
   a_sample_edge: assert property (mst && samp |-> (sclk_r == cpol) == !cpha)
      else $error("master sampled on wrong edge");
   a_char_bits: assert property (done |->
      scnt_r + {4'h0, samp} == (chr ? sfb_pkg::BITS_16 : sfb_pkg::BITS_8))
      else $error("wrong number of bits in transfer");
   a_rsvd_zero: assert property (fmt_r[5:3] == 3'h0)
      else $error("reserved format bits not zero");
   a_sel_level: assert property (!mst && ss_q[1] != select_level_bit ##1 !mst |-> !busy)
      else $error("slave busy while deselected");
   a_irq_gate: assert property (!ie |=> !o_irq)
      else $error("interrupt raised while disabled");
   a_irq_done: assert property (ie && done |=> o_irq)
      else $error("no interrupt after transfer end");
   a_slave_nodiv: assert property (!mst |-> !tick)
      else $error("clock generator running in slave mode");
   a_mst_guard: assert property (wr_ctl && !mst && ss_act |=> !mst)
      else $error("master enabled while select active");
   a_write_collision_flag_set: assert property (wr_data && busy |=> flg_r[sfb_pkg::S_WRITE_COLLISION_FLAG])
      else $error("write collision not flagged");
   a_done_flag: assert property (done |=> flg_r[sfb_pkg::S_DONE] && !busy)
      else $error("transfer end not flagged");

   // ===================================================
   // Flag, pin, divider and receive length checks
   a_ovr_set: assert property (done && rxf_r |=> flg_r[sfb_pkg::S_RECEIVE_OVERRUN_FLAG])
      else $error("receive overrun not flagged");
   a_fault_abort: assert property (fault && !wr_data |=> flg_r[sfb_pkg::S_MODE_FAULT_FLAG] && !busy)
      else $error("mode fault not flagged or transfer not aborted");
   a_flag_sticky: assert property (!wr_stat |=> (flg_r | $past(flg_r)) == flg_r)
      else $error("flag dropped without a software write");
   a_set_wins: assert property (wr_stat && done |=> flg_r[sfb_pkg::S_DONE])
      else $error("software clear beat transfer end");
   a_sw_irq: assert property (ie && wr_stat && wdata_r[sfb_pkg::S_DONE] |=> o_irq)
      else $error("software set of done flag raised no interrupt");
   a_write_collision_flag_idle: assert property (wr_data && !busy |=>
      flg_r[sfb_pkg::S_WRITE_COLLISION_FLAG] == $past(flg_r[sfb_pkg::S_WRITE_COLLISION_FLAG]))
      else $error("write collision flagged while idle");
   a_div_hold: assert property (!wr_div |=> div_r == $past(div_r))
      else $error("divider changed without a write");
   a_slave_pins: assert property (!mst |-> !o_sclk_oe && !o_mosi_oe)
      else $error("master pins driven in slave mode");
   a_rx_len: assert property (done && !rxf_r && !chr |=> rxb_r[15:8] == 8'h00)
      else $error("short character has upper bits set");

   c_master_8: cover property (mst && !chr && done);
   c_master_16: cover property (mst && chr && done);
   c_slave_done: cover property (!mst && done);
   c_write_collision_flag: cover property (wr_data && busy);
   c_mode_fault: cover property (fault);
endmodule : sfb_spi_top
`default_nettype wire

// File: sim/sfb_spi_partner.sv
// Behavioural external SPI slave that answers the port in master operation
`timescale 1ns/1ps
`default_nettype none
module sfb_spi_partner (
   input  wire logic        i_en,
   input  wire logic        i_sclk,
   input  wire logic        i_mosi,
   input  wire logic        i_cpol,
   input  wire logic        i_cpha,
   input  wire logic        i_len16,
   input  wire logic [15:0] i_tx,
   input  wire logic [8:0]  i_half,
   output logic             o_miso,
   output logic [15:0]      o_rx,
   output int               o_edges,
   output int               o_gap_err
);
   logic    samp_rise;
   logic    miso_r = 1'b0;
   logic    en_q   = 1'b0;
   int      k;
   int      bits;
   realtime last_t;

   // Sampling edge from polarity and phase, same for both directions
   assign samp_rise = (i_cpol == i_cpha);
   assign o_miso    = miso_r;

   always @(i_en or i_sclk) begin
      if (i_en && !en_q) begin
         k = 0;
         o_edges = 0;
         o_gap_err = 0;
         o_rx = 16'h0000;
         bits = i_len16 ? 16 : 8;
         miso_r = i_tx[bits-1];
      end else if (!i_en && en_q) begin
         // Released line: show the inverse of the last bit
         miso_r = ~miso_r;
      end else if (i_en) begin
         if (o_edges > 0 && ($realtime - last_t) != i_half * 10.0) o_gap_err++;
         last_t = $realtime;
         o_edges++;
         if (i_sclk == samp_rise) begin
            o_rx = {o_rx[14:0], i_mosi};
            k++;
         end else if (k < bits) begin
            miso_r = i_tx[bits-1-k];
         end
      end
      en_q = i_en;
   end
endmodule : sfb_spi_partner
`default_nettype wire

// File: sim/spi_format_and_baud_config_tb.sv
// Self-checking bench for the SPI format and baud block
`timescale 1ns/1ps
`default_nettype none
`define SFB_CHECK(nm, exp, got) begin comparisons++; if ((got) !== (exp)) begin fail_count++; $display("mismatch %s expected %h seen %h", nm, exp, got); end end
module spi_format_and_baud_config_tb;
   localparam logic [9:0] A_FMT  = {sfb_pkg::IDX_FMT, 2'b00};
   localparam logic [9:0] A_DIV  = {sfb_pkg::IDX_DIV, 2'b00};
   localparam logic [9:0] A_CTL  = {sfb_pkg::IDX_CTL, 2'b00};
   localparam logic [9:0] A_STAT = {sfb_pkg::IDX_STAT, 2'b00};
   localparam logic [9:0] A_DATA = {sfb_pkg::IDX_DATA, 2'b00};
   localparam logic [9:0] A_BAD  = 10'h3FC;
   logic                  sys_clk, rst, sclk_in, mosi_in, ssel, sclk, sclk_oe, mosi, mosi_oe;
   logic                  miso_dev, miso_oe, miso_p, irq, p_en, p_cpol, p_cpha, p_len16, unread;
   logic [15:0]           p_tx, p_rx, last_rx, s_got;
   logic [8:0]            p_half;
   logic [31:0]           d;
   logic [1:0]            r;
   int                    p_edges, p_gap_err, fail_count, comparisons, seed, i;
   sfb_pkg::sfb_axi_req_t axi_req;
   sfb_pkg::sfb_axi_rsp_t axi_rsp;

   sfb_spi_top u_sfb_spi_top (.i_sys_clk(sys_clk), .i_rst(rst), .i_axi(axi_req), .o_axi(axi_rsp),
      .i_sclk(sclk_in), .o_sclk(sclk), .o_sclk_oe(sclk_oe), .i_mosi(mosi_in), .o_mosi(mosi),
      .o_mosi_oe(mosi_oe), .i_miso(miso_p), .o_miso(miso_dev), .o_miso_oe(miso_oe),
      .i_ssel(ssel), .o_irq(irq));
   sfb_spi_partner u_sfb_spi_partner (.i_en(p_en), .i_sclk(sclk), .i_mosi(mosi), .i_cpol(p_cpol),
      .i_cpha(p_cpha), .i_len16(p_len16), .i_tx(p_tx), .i_half(p_half), .o_miso(miso_p),
      .o_rx(p_rx), .o_edges(p_edges), .o_gap_err(p_gap_err));

   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   // ===================================================
   // Bus tasks and expectations
   task automatic wr(input logic [9:0] a, input logic [31:0] dv, output logic [1:0] rs);
      int n;
      @(posedge sys_clk);
      n = 0;
      axi_req.awvalid <= 1'b1;
      axi_req.awaddr <= a;
      axi_req.wvalid <= 1'b1;
      axi_req.wdata <= dv;
      axi_req.wstrb <= 4'hF;
      axi_req.bready <= 1'b1;
      do begin
         @(posedge sys_clk);
         n++;
         if (axi_req.awvalid && axi_rsp.awready) axi_req.awvalid <= 1'b0;
         if (axi_req.wvalid && axi_rsp.wready) axi_req.wvalid <= 1'b0;
      end while (axi_rsp.bvalid !== 1'b1 && n < 100);
      rs = axi_rsp.bresp;
      axi_req.bready <= 1'b0;
      if (n >= 100) fail_count++;
   endtask : wr

   task automatic rd(input logic [9:0] a, output logic [31:0] dv, output logic [1:0] rs);
      int n;
      @(posedge sys_clk);
      n = 0;
      axi_req.arvalid <= 1'b1;
      axi_req.araddr <= a;
      axi_req.rready <= 1'b1;
      do begin
         @(posedge sys_clk);
         n++;
         if (axi_req.arvalid && axi_rsp.arready) axi_req.arvalid <= 1'b0;
      end while (axi_rsp.rvalid !== 1'b1 && n < 100);
      dv = axi_rsp.rdata;
      rs = axi_rsp.rresp;
      axi_req.rready <= 1'b0;
      if (n >= 100) fail_count++;
   endtask : rd

   task automatic wreg(input logic [9:0] a, input logic [31:0] dv);
      logic [1:0] rs;
      wr(a, dv, rs);
      `SFB_CHECK("write response", sfb_pkg::RESP_OKAY, rs)
   endtask : wreg

   task automatic rchk(input string nm, input logic [9:0] a, input logic [31:0] e);
      logic [31:0] dv;
      logic [1:0]  rs;
      rd(a, dv, rs);
      `SFB_CHECK(nm, e, dv)
   endtask : rchk

   function automatic logic [31:0] fmt_exp(input logic [31:0] v);
      return {24'h0, v[7:6], 3'b000, v[2:0]};
   endfunction : fmt_exp

   function automatic logic [15:0] char_mask(input logic [15:0] v, input logic len16);
      return len16 ? v : {8'h00, v[7:0]};
   endfunction : char_mask

   // One master transfer against the partner, m = {length, phase, polarity}
   task automatic xfer(input logic [2:0] m, input logic ie, input logic coll, input logic rdd);
      logic [15:0] mtx, stx;
      logic [7:0]  ratio;
      logic [31:0] st;
      logic [1:0]  rs;
      int          n;
      mtx = 16'($random(seed));
      stx = 16'($random(seed));
      ratio = 8'h02 + 8'($unsigned($random(seed)) % 3);
      wreg(A_FMT, {24'h0, ie, 4'h0, m});
      wreg(A_DIV, {24'h0, ratio});
      wreg(A_CTL, 32'h1);
      p_cpol <= m[0];
      p_cpha <= m[1];
      p_len16 <= m[2];
      p_tx <= stx;
      p_half <= {1'b0, ratio} + 9'h1;
      @(posedge sys_clk);
      p_en <= 1'b1;
      wreg(A_DATA, {16'h0, mtx});
      if (coll) wreg(A_DATA, {16'h0, ~mtx});
      n = 0;
      do begin
         rd(A_STAT, st, rs);
         n++;
      end while (st[7] !== 1'b0 && n < 200);
      `SFB_CHECK("char sent", char_mask(mtx, m[2]), p_rx)
      `SFB_CHECK("clock edges", (m[2] ? 32 : 16), p_edges)
      `SFB_CHECK("half period errors", 0, p_gap_err)
      `SFB_CHECK("status flags", {1'b1, unread, coll, 1'b0}, st[3:0])
      `SFB_CHECK("interrupt on flags", ie, irq)
      if (!unread) last_rx = char_mask(stx, m[2]);
      unread = 1'b1;
      if (rdd) begin
         rchk("char received", A_DATA, {16'h0, last_rx});
         unread = 1'b0;
      end
      wreg(A_STAT, 32'h0);
      p_en <= 1'b0;
      @(posedge sys_clk);
      `SFB_CHECK("interrupt after clear", 1'b0, irq)
   endtask : xfer

   task automatic conclude();
      if (fail_count == 0 && comparisons > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : conclude

   initial begin
      #500000;
      fail_count++;
      conclude();
   end

   // ===================================================
   // Main sequence
   initial begin
      axi_req = '0;
      {rst, sclk_in, mosi_in, ssel} = 4'b1001;
      {p_en, p_cpol, p_cpha, p_len16, unread} = 5'h00;
      p_tx = 16'h0000;
      last_rx = 16'h0000;
      p_half = 9'h001;
      seed = 70;
      fail_count = 0;
      comparisons = 0;
      repeat (3) @(posedge sys_clk);
      rst <= 1'b0;
      rchk("format reset", A_FMT, 32'h0);
      rchk("divider reset", A_DIV, 32'h0);
      `SFB_CHECK("interrupt idle", 1'b0, irq)
      for (i = 0; i < 8; i++) begin
         d = (i == 0) ? 32'hFFFFFFFF : $random(seed);
         wreg(A_FMT, d);
         rchk("format readback", A_FMT, fmt_exp(d));
         wreg(A_DIV, d);
         rchk("divider readback", A_DIV, {24'h0, d[7:0]});
      end
      wr(A_BAD, 32'h0000005A, r);
      `SFB_CHECK("unmapped write response", sfb_pkg::RESP_SLVERR, r)
      rd(A_FMT + 10'h001, d, r);
      `SFB_CHECK("misaligned read response", sfb_pkg::RESP_SLVERR, r)
      wreg(A_DIV, 32'h0);
      for (i = 0; i < 4; i++) begin
         wreg(A_FMT, {24'h0, 1'b0, i[1], 6'h00});
         ssel <= i[0];
         repeat (6) @(posedge sys_clk);
         `SFB_CHECK("slave output enable", (i[1] == i[0]), miso_oe)
         `SFB_CHECK("clock enable in slave", 1'b0, sclk_oe)
         `SFB_CHECK("clock idle in slave", 1'b0, sclk)
      end
      ssel <= 1'b0;
      wreg(A_FMT, 32'h0);
      wreg(A_CTL, 32'h1);
      rchk("master under select", A_CTL, 32'h0);
      ssel <= 1'b1;
      repeat (4) @(posedge sys_clk);
      for (i = 0; i < 8; i++) xfer(i[2:0], i[0] ^ i[1], (i == 3), 1'b1);
      xfer(3'b101, 1'b1, 1'b0, 1'b0);
      xfer(3'b101, 1'b1, 1'b0, 1'b1);
      for (i = 0; i < 8; i++) begin
         wreg(A_FMT, {24'h0, i[0], 7'h00});
         wreg(A_STAT, 32'h1 << i[2:1]);
         @(posedge sys_clk);
         `SFB_CHECK("software flag interrupt", i[0], irq)
         wreg(A_STAT, 32'h0);
      end
      wreg(A_FMT, 32'h0);
      wreg(A_CTL, 32'h3);
      ssel <= 1'b0;
      repeat (6) @(posedge sys_clk);
      rchk("mode fault flag", A_STAT, 32'h1);
      ssel <= 1'b1;
      wreg(A_STAT, 32'h0);
      wreg(A_CTL, 32'h0);
      // Slave transfer in mode 0, the bench plays the master
      d = $random(seed);
      wreg(A_DATA, {24'h0, d[7:0]});
      ssel <= 1'b0;
      for (i = 7; i >= 0; i--) begin
         mosi_in <= d[8+i];
         repeat (4) @(posedge sys_clk);
         s_got[i] = miso_dev;
         sclk_in <= 1'b1;
         repeat (4) @(posedge sys_clk);
         sclk_in <= 1'b0;
      end
      repeat (6) @(posedge sys_clk);
      `SFB_CHECK("slave char sent", d[7:0], s_got[7:0])
      rchk("slave char received", A_DATA, {24'h0, d[15:8]});
      rchk("slave status", A_STAT, 32'h8);
      ssel <= 1'b1;
      conclude();
   end
endmodule : spi_format_and_baud_config_tb
`default_nettype wire
